// File: shared/sdd_pkg.sv
// Constants and types shared by the card delay configuration bank.
package sdd_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register offsets on the configuration port.
    localparam logic [15:0] SDD_OFS_CLASSIC = 16'h184b;
    localparam logic [15:0] SDD_OFS_HSPEED  = 16'h184c;
    localparam logic [15:0] SDD_OFS_MMC     = 16'h184d;
    localparam logic [15:0] SDD_OFS_PAD     = 16'h1880;
    localparam logic [15:0] SDD_OFS_STATUS  = 16'h1881;

    ////////////////////////////////////////////////////////////////////////
    // Reset values.
    localparam logic [7:0] SDD_RST_CLASSIC = 8'h59;
    localparam logic [7:0] SDD_RST_HSPEED  = 8'h54;
    localparam logic [7:0] SDD_RST_MMC     = 8'h95;
    localparam logic [1:0] SDD_RST_PAD     = 2'h0;

    ////////////////////////////////////////////////////////////////////////
    // Field positions inside a delay register and the pad register.
    localparam int SDD_RB_MSB  = 7;
    localparam int SDD_RB_LSB  = 6;
    localparam int SDD_CP_MSB  = 5;
    localparam int SDD_CP_LSB  = 4;
    localparam int SDD_CD_MSB  = 3;
    localparam int SDD_CD_LSB  = 0;
    localparam int SDD_PAD_MSB = 1;
    localparam int SDD_PAD_LSB = 0;

    // Status register fields.
    localparam int SDD_ST_CARD_MSB = 1;
    localparam int SDD_ST_CARD_LSB = 0;
    localparam int SDD_ST_BUSY     = 2;

    ////////////////////////////////////////////////////////////////////////
    // Depth of the longest selectable chain, in register stages.
    localparam int SDD_MAX_STAGES = 4;
    // Width of the sampled card lines: command plus four data lines.
    localparam int SDD_LINE_W     = 5;

    typedef enum logic [1:0] {
        SDD_CARD_CLASSIC = 2'h0,
        SDD_CARD_HSPEED  = 2'h1,
        SDD_CARD_MMC     = 2'h2
    } sdd_card_e;

    typedef enum logic [1:0] {
        SDD_XS_IDLE = 2'b01,
        SDD_XS_WAIT = 2'b10
    } sdd_xfer_e;

endpackage

// File: shared/sdd_link_if.sv
// Signals between the system-clock bank and its card-clock side.
`timescale 1ns/1ps
`default_nettype none

interface sdd_link_if;
    logic       req_t;
    logic [3:0] req_tap;
    logic       ack_t;
    logic [4:0] samp;

    modport core (output req_t, output req_tap, input ack_t, input samp);
    modport link (input req_t, input req_tap, output ack_t, output samp);
endinterface

`default_nettype wire

// File: logic/sdd_link_side.sv
// Card-clock side: capture of card lines and the applied capture delay tap.
`timescale 1ns/1ps
`default_nettype none

module sdd_link_side (
    input  wire logic       link_clk,
    input  wire logic       nrst,
    input  wire logic       card_cmd,
    input  wire logic [3:0] card_dat,
    output logic [3:0]      capture_tap,
    sdd_link_if.link        lnk
);

    typedef struct packed {
        logic [1:0] rq_s;
        logic       rq_prev;
        logic [3:0] tap;
        logic       ack;
        logic [4:0] samp;
    } sdd_link_s;

    sdd_link_s st_ff;
    sdd_link_s nxt_st;

    ////////////////////////////////////////////////////////////////////////
    // The request toggle passes two flops; the tap word is held stable by
    // the system side until the acknowledge returns, so it is safe to take.
    always_comb begin
        nxt_st         = st_ff;
        nxt_st.rq_s    = {st_ff.rq_s[0], lnk.req_t};
        nxt_st.samp    = {card_cmd, card_dat};
        if (st_ff.rq_s[1] != st_ff.rq_prev) begin
            nxt_st.rq_prev = st_ff.rq_s[1];
            nxt_st.tap     = lnk.req_tap;
            nxt_st.ack     = st_ff.rq_s[1];
        end
    end

    always_ff @(posedge link_clk or negedge nrst) begin
        if (!nrst) begin
            st_ff <= '{rq_s: 2'h0, rq_prev: 1'b0, tap: sdd_pkg::SDD_RST_CLASSIC[3:0],
                       ack: 1'b0, samp: 5'h00};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign capture_tap = st_ff.tap;
    assign lnk.ack_t   = st_ff.ack;
    assign lnk.samp    = st_ff.samp;

endmodule

`default_nettype wire

// File: logic/sdd_delay_bank.sv
// Delay and pad drive configuration bank for the card controller.
`timescale 1ns/1ps
`default_nettype none

module sdd_delay_bank (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        link_clk,
    input  wire logic [15:0] addr,
    input  wire logic [7:0]  wdata,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    output logic [7:0]       rdata,
    input  wire logic [1:0]  card_type,
    input  wire logic        card_cmd,
    input  wire logic [3:0]  card_dat,
    input  wire logic        ctrl_in,
    output logic             ctrl_out,
    output logic             sync_cmd,
    output logic [3:0]       sync_dat,
    output logic [1:0]       pad_drive,
    output logic [1:0]       readback_sync_depth,
    output logic [1:0]       control_pipe_delay,
    output logic [3:0]       capture_clock_delay,
    output logic [3:0]       capture_tap_link
);

    typedef struct packed {
        logic [7:0]          cls;
        logic [7:0]          hsd;
        logic [7:0]          mmc;
        logic [1:0]          pad;
        logic [7:0]          rdata;
        logic [7:0]          act;
        logic [1:0]          act_card;
        logic [3:0][4:0]     rs;
        logic [3:0]          pipe;
        sdd_pkg::sdd_xfer_e  xs;
        logic                req_t;
        logic [3:0]          req_tap;
        logic [1:0]          ack_s;
        logic                ack_prev;
    } sdd_bank_s;

    sdd_bank_s  st_ff;
    sdd_bank_s  nxt_st;
    logic [1:0] rb_entry;
    logic [1:0] cp_entry;

    sdd_link_if u_if ();

    ////////////////////////////////////////////////////////////////////////
    // Entry stage of a four-stage chain; the last stage is always the output,
    // so entering further down shortens the chain.
    function automatic logic [1:0] entry_of(input logic [1:0] code);
        case (code)
            2'h0: begin
                entry_of = 2'h2;
            end
            2'h1: begin
                entry_of = 2'h1;
            end
            default: begin
                entry_of = 2'h0;
            end
        endcase
    endfunction

    // Delay register that belongs to a card type.
    function automatic logic [7:0] cfg_of(input sdd_bank_s s, input logic [1:0] ct);
        case (ct)
            sdd_pkg::SDD_CARD_HSPEED: begin
                cfg_of = s.hsd;
            end
            sdd_pkg::SDD_CARD_MMC: begin
                cfg_of = s.mmc;
            end
            default: begin
                cfg_of = s.cls;
            end
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Card-clock side.
    sdd_link_side u_link (
        .link_clk    (link_clk),
        .nrst        (nrst),
        .card_cmd    (card_cmd),
        .card_dat    (card_dat),
        .capture_tap (capture_tap_link),
        .lnk         (u_if.link)
    );

    assign u_if.req_t   = st_ff.req_t;
    assign u_if.req_tap = st_ff.req_tap;

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic.
    always_comb begin
        nxt_st   = st_ff;
        rb_entry = entry_of(st_ff.act[sdd_pkg::SDD_RB_MSB:sdd_pkg::SDD_RB_LSB]);
        cp_entry = entry_of(st_ff.act[sdd_pkg::SDD_CP_MSB:sdd_pkg::SDD_CP_LSB]);

        if (wr_en) begin
            if (addr == sdd_pkg::SDD_OFS_CLASSIC) begin
                nxt_st.cls = wdata;
            end else if (addr == sdd_pkg::SDD_OFS_HSPEED) begin
                nxt_st.hsd = wdata;
            end else if (addr == sdd_pkg::SDD_OFS_MMC) begin
                nxt_st.mmc = wdata;
            end else if (addr == sdd_pkg::SDD_OFS_PAD) begin
                nxt_st.pad = wdata[sdd_pkg::SDD_PAD_MSB:sdd_pkg::SDD_PAD_LSB];
            end
        end

        // Read data stand only in the cycle after the strobe; zero otherwise.
        nxt_st.rdata = 8'h00;
        if (rd_en) begin
            if (addr == sdd_pkg::SDD_OFS_CLASSIC) begin
                nxt_st.rdata = st_ff.cls;
            end else if (addr == sdd_pkg::SDD_OFS_HSPEED) begin
                nxt_st.rdata = st_ff.hsd;
            end else if (addr == sdd_pkg::SDD_OFS_MMC) begin
                nxt_st.rdata = st_ff.mmc;
            end else if (addr == sdd_pkg::SDD_OFS_PAD) begin
                nxt_st.rdata = {6'h00, st_ff.pad};
            end else if (addr == sdd_pkg::SDD_OFS_STATUS) begin
                nxt_st.rdata = {5'h00, (st_ff.xs == sdd_pkg::SDD_XS_WAIT), st_ff.act_card};
            end
        end

        nxt_st.act      = cfg_of(st_ff, card_type);
        nxt_st.act_card = card_type;

        // Card lines come from the card clock; the chain starts at two stages.
        nxt_st.rs[0] = (rb_entry == 2'h0) ? u_if.samp : 5'h00;
        for (int k = 1; k < sdd_pkg::SDD_MAX_STAGES; k++) begin
            nxt_st.rs[k] = (rb_entry == 2'(k)) ? u_if.samp : st_ff.rs[k - 1];
        end

        nxt_st.pipe[0] = (cp_entry == 2'h0) ? ctrl_in : 1'b0;
        for (int k = 1; k < sdd_pkg::SDD_MAX_STAGES; k++) begin
            nxt_st.pipe[k] = (cp_entry == 2'(k)) ? ctrl_in : st_ff.pipe[k - 1];
        end

        // Tap word crossing: a toggle with the word held until acknowledged.
        nxt_st.ack_s = {st_ff.ack_s[0], u_if.ack_t};
        case (st_ff.xs)
            sdd_pkg::SDD_XS_IDLE: begin
                if (st_ff.act[sdd_pkg::SDD_CD_MSB:sdd_pkg::SDD_CD_LSB] != st_ff.req_tap) begin
                    nxt_st.req_tap = st_ff.act[sdd_pkg::SDD_CD_MSB:sdd_pkg::SDD_CD_LSB];
                    nxt_st.req_t   = ~st_ff.req_t;
                    nxt_st.xs      = sdd_pkg::SDD_XS_WAIT;
                end
            end
            sdd_pkg::SDD_XS_WAIT: begin
                if (st_ff.ack_s[1] != st_ff.ack_prev) begin
                    nxt_st.ack_prev = st_ff.ack_s[1];
                    nxt_st.xs       = sdd_pkg::SDD_XS_IDLE;
                end
            end
            default: begin
                nxt_st.xs = sdd_pkg::SDD_XS_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // State register.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_ff.cls      <= sdd_pkg::SDD_RST_CLASSIC;
            st_ff.hsd      <= sdd_pkg::SDD_RST_HSPEED;
            st_ff.mmc      <= sdd_pkg::SDD_RST_MMC;
            st_ff.pad      <= sdd_pkg::SDD_RST_PAD;
            st_ff.rdata    <= 8'h00;
            st_ff.act      <= sdd_pkg::SDD_RST_CLASSIC;
            st_ff.act_card <= sdd_pkg::SDD_CARD_CLASSIC;
            st_ff.rs       <= '0;
            st_ff.pipe     <= 4'h0;
            st_ff.xs       <= sdd_pkg::SDD_XS_IDLE;
            st_ff.req_t    <= 1'b0;
            st_ff.req_tap  <= sdd_pkg::SDD_RST_CLASSIC[3:0];
            st_ff.ack_s    <= 2'h0;
            st_ff.ack_prev <= 1'b0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs.
    assign rdata               = st_ff.rdata;
    assign ctrl_out            = st_ff.pipe[3];
    assign sync_cmd            = st_ff.rs[3][4];
    assign sync_dat            = st_ff.rs[3][3:0];
    assign pad_drive           = st_ff.pad;
    assign readback_sync_depth = st_ff.act[sdd_pkg::SDD_RB_MSB:sdd_pkg::SDD_RB_LSB];
    assign control_pipe_delay  = st_ff.act[sdd_pkg::SDD_CP_MSB:sdd_pkg::SDD_CP_LSB];
    assign capture_clock_delay = st_ff.act[sdd_pkg::SDD_CD_MSB:sdd_pkg::SDD_CD_LSB];

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    property p_sync_three;
        @(posedge clk) disable iff (!nrst)
        (readback_sync_depth == 2'b01) [*4] |-> ({sync_cmd, sync_dat} == $past(st_ff.rs[1], 2));
    endproperty
    a_sync_three: assert property (p_sync_three) else $error("three-stage sync wrong");

    property p_pipe_two;
        @(posedge clk) disable iff (!nrst)
        (control_pipe_delay == 2'b00) [*3] |-> (ctrl_out == $past(ctrl_in, 2));
    endproperty
    a_pipe_two: assert property (p_pipe_two) else $error("two-stage control delay wrong");

    property p_pipe_undef;
        @(posedge clk) disable iff (!nrst)
        (control_pipe_delay == 2'b11) [*5] |-> (ctrl_out == $past(ctrl_in, 4));
    endproperty
    a_pipe_undef: assert property (p_pipe_undef) else $error("code 11 not four stages");

    property p_tap_write;
        @(posedge clk) disable iff (!nrst)
        (wr_en && addr == sdd_pkg::SDD_OFS_CLASSIC && card_type == sdd_pkg::SDD_CARD_CLASSIC)
        ##1 (card_type == sdd_pkg::SDD_CARD_CLASSIC && !wr_en)
        |=> (capture_clock_delay == $past(wdata[3:0], 2));
    endproperty
    a_tap_write: assert property (p_tap_write) else $error("capture delay not applied");

    property p_reset_vals;
        @(posedge clk) disable iff (!nrst)
        $rose(nrst) |-> (st_ff.cls == 8'h59 && st_ff.hsd == 8'h54 && st_ff.mmc == 8'h95);
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("delay reset values wrong");

    property p_pad_read;
        @(posedge clk) disable iff (!nrst)
        (rd_en && addr == sdd_pkg::SDD_OFS_PAD) |=> (rdata == {6'h00, pad_drive});
    endproperty
    a_pad_read: assert property (p_pad_read) else $error("pad register read wrong");

    property p_card_sel;
        @(posedge clk) disable iff (!nrst)
        (card_type == sdd_pkg::SDD_CARD_MMC) |=> ({readback_sync_depth, control_pipe_delay,
                                                   capture_clock_delay} == $past(st_ff.mmc));
    endproperty
    a_card_sel: assert property (p_card_sel) else $error("wrong card register applied");

    property p_sync_two;
        @(posedge clk) disable iff (!nrst)
        (readback_sync_depth == 2'b00) [*3] |-> ({sync_cmd, sync_dat} == $past(u_if.samp, 2));
    endproperty
    a_sync_two: assert property (p_sync_two) else $error("two-stage sync wrong");

    property p_sync_four;
        @(posedge clk) disable iff (!nrst)
        (readback_sync_depth == 2'b10) [*5] |-> ({sync_cmd, sync_dat} == $past(u_if.samp, 4));
    endproperty
    a_sync_four: assert property (p_sync_four) else $error("four-stage sync wrong");

    property p_sync_undef;
        @(posedge clk) disable iff (!nrst)
        (readback_sync_depth == 2'b11) [*5] |-> ({sync_cmd, sync_dat} == $past(u_if.samp, 4));
    endproperty
    a_sync_undef: assert property (p_sync_undef) else $error("sync code 11 not four stages");

    property p_pipe_three;
        @(posedge clk) disable iff (!nrst)
        (control_pipe_delay == 2'b01) [*4] |-> (ctrl_out == $past(ctrl_in, 3));
    endproperty
    a_pipe_three: assert property (p_pipe_three) else $error("three-stage control delay wrong");

    property p_pipe_four;
        @(posedge clk) disable iff (!nrst)
        (control_pipe_delay == 2'b10) [*5] |-> (ctrl_out == $past(ctrl_in, 4));
    endproperty
    a_pipe_four: assert property (p_pipe_four) else $error("four-stage control delay wrong");

    property p_pad_write;
        @(posedge clk) disable iff (!nrst)
        (wr_en && addr == sdd_pkg::SDD_OFS_PAD) |=> (pad_drive == $past(wdata[1:0]));
    endproperty
    a_pad_write: assert property (p_pad_write) else $error("pad current select not written");

    property p_hsd_sel;
        @(posedge clk) disable iff (!nrst)
        (card_type == sdd_pkg::SDD_CARD_HSPEED)
        |=> ({readback_sync_depth, control_pipe_delay, capture_clock_delay} == $past(st_ff.hsd));
    endproperty
    a_hsd_sel: assert property (p_hsd_sel) else $error("high-speed register not applied");

    property p_cls_sel;
        @(posedge clk) disable iff (!nrst)
        (card_type == sdd_pkg::SDD_CARD_CLASSIC || card_type == 2'h3)
        |=> ({readback_sync_depth, control_pipe_delay, capture_clock_delay} == $past(st_ff.cls));
    endproperty
    a_cls_sel: assert property (p_cls_sel) else $error("classic register not applied");

endmodule

`default_nettype wire

// File: tb/sdd_card_model.sv
// Behavioural memory card that drives the command and data lines seen by the bank.
`timescale 1ns/1ps
`default_nettype none

module sdd_card_model (
    input  wire logic       link_clk,
    input  wire logic       frame,
    input  wire logic       cmd_val,
    input  wire logic [3:0] dat_val,
    output logic            card_cmd,
    output logic [3:0]      card_dat
);
    // Lines change on the falling card clock edge so the rising capture edge sees them settled.
    // Outside a frame the card lets go and the pull-ups hold every line high.
    always @(negedge link_clk or negedge frame) begin
        if (!frame) begin
            card_cmd <= 1'b1;
            card_dat <= 4'hf;
        end else begin
            card_cmd <= cmd_val;
            card_dat <= dat_val;
        end
    end
endmodule

`default_nettype wire

// File: tb/tb_sd_card_delay_config.sv
// Self-checking bench for the card delay configuration bank.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin miscompares++; \
    $display("ERROR %s expected %h seen %h", nm, exp, got); end end

module tb_sd_card_delay_config;
    localparam logic [15:0] OFS [4] = '{sdd_pkg::SDD_OFS_CLASSIC, sdd_pkg::SDD_OFS_HSPEED,
                                        sdd_pkg::SDD_OFS_MMC, sdd_pkg::SDD_OFS_PAD};
    localparam logic [7:0]  RSTV [4] = '{sdd_pkg::SDD_RST_CLASSIC, sdd_pkg::SDD_RST_HSPEED,
                                         sdd_pkg::SDD_RST_MMC, 8'h00};
    localparam logic [7:0]  NEWV [3] = '{8'h17, 8'h6c, 8'ha3};
    logic        clk = 1'b0, nrst = 1'b0, link_clk = 1'b0, frame = 1'b1;
    logic        wr_en = 1'b0, rd_en = 1'b0, ctrl_in = 1'b0, cmd_val = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [7:0]  wdata = 8'h00, rdata, rd, ev;
    logic [1:0]  card_type = 2'h0, pad_drive, readback_sync_depth, control_pipe_delay;
    logic [3:0]  dat_val = 4'h0, card_dat, sync_dat, capture_clock_delay, capture_tap_link;
    logic        card_cmd, ctrl_out, sync_cmd;
    int          miscompares = 0, checks_done = 0, n;

    always #50 clk = ~clk;
    always #15 if (frame) link_clk = ~link_clk;

    sdd_card_model card (.link_clk(link_clk), .frame(frame), .cmd_val(cmd_val), .dat_val(dat_val),
                         .card_cmd(card_cmd), .card_dat(card_dat));

    sdd_delay_bank dut (.clk(clk), .nrst(nrst), .link_clk(link_clk), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .card_type(card_type), .card_cmd(card_cmd),
        .card_dat(card_dat), .ctrl_in(ctrl_in), .ctrl_out(ctrl_out), .sync_cmd(sync_cmd),
        .sync_dat(sync_dat), .pad_drive(pad_drive), .readback_sync_depth(readback_sync_depth),
        .control_pipe_delay(control_pipe_delay), .capture_clock_delay(capture_clock_delay),
        .capture_tap_link(capture_tap_link));

    ////////////////////////////////////////////////////////////////////////
    task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask

    task automatic reg_rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask

    // Programs both depth fields with one code and times the control and readback chains.
    task automatic chain_check(input logic [1:0] code);
        int dep;
        dep = (code == 2'h0) ? 2 : (code == 2'h1) ? 3 : 4;
        reg_wr(sdd_pkg::SDD_OFS_CLASSIC, {code, code, 4'h9});
        repeat (6) @(posedge clk);
        `CHK("rb_field", code, readback_sync_depth)
        `CHK("cp_field", code, control_pipe_delay)
        ctrl_in <= 1'b1;
        @(posedge clk);
        ctrl_in <= 1'b0;
        n = 0;
        do begin @(negedge clk); n++; end while (ctrl_out !== 1'b1 && n < 9);
        `CHK("ctrl_delay", dep, n)
        repeat (6) @(posedge clk);
        cmd_val <= 1'b1;
        dat_val <= 4'ha;
        n = 0;
        do begin @(negedge clk); n++; end while (sync_cmd !== 1'b1 && n < 9);
        // Card and link capture always land within one system cycle here, so one cycle is added.
        `CHK("sync_latency", dep + 1, n)
        `CHK("sync_dat", 4'ha, sync_dat)
        @(posedge clk);
        cmd_val <= 1'b0;
        dat_val <= 4'h0;
        repeat (8) @(posedge clk);
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        #5_000_000;
        miscompares++;
        test_done();
    end

    initial begin
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        `CHK("rb_reset", 2'h1, readback_sync_depth)
        `CHK("cp_reset", 2'h1, control_pipe_delay)
        `CHK("cd_reset", 4'h9, capture_clock_delay)
        `CHK("tap_reset", 4'h9, capture_tap_link)
        `CHK("pad_reset", 2'h0, pad_drive)
        for (int i = 0; i < 4; i++) begin
            reg_rd(OFS[i], rd);
            `CHK("reset_value", RSTV[i], rd)
        end
        $display("test reset_values done");

        for (int i = 0; i < 3; i++) begin
            reg_wr(OFS[i], NEWV[i]);
            reg_rd(OFS[i], rd);
            `CHK("delay_readback", NEWV[i], rd)
        end
        for (int c = 0; c < 4; c++) begin
            reg_wr(sdd_pkg::SDD_OFS_PAD, {6'h3f, c[1:0]});
            reg_rd(sdd_pkg::SDD_OFS_PAD, rd);
            `CHK("pad_readback", {6'h00, c[1:0]}, rd)
            `CHK("pad_drive", c[1:0], pad_drive)
        end
        reg_rd(16'h1850, rd);
        `CHK("unmapped_read", 8'h00, rd)
        reg_wr(sdd_pkg::SDD_OFS_STATUS, 8'hff);
        reg_rd(sdd_pkg::SDD_OFS_STATUS, rd);
        `CHK("status_readonly", 8'h00, rd)
        $display("test register_access done");

        // Status shows the selected card and, while a new tap is in flight, the busy bit.
        for (int t = 0; t < 4; t++) begin
            @(posedge clk);
            card_type <= t[1:0];
            ev = (t == 3) ? NEWV[0] : NEWV[t];
            @(posedge clk);
            reg_rd(sdd_pkg::SDD_OFS_STATUS, rd);
            `CHK("status_card", {5'h00, (t != 0), t[1:0]}, rd)
            `CHK("active_fields", ev, {readback_sync_depth, control_pipe_delay, capture_clock_delay})
            n = 0;
            while (capture_tap_link !== ev[3:0] && n < 60) begin @(posedge clk); n++; end
            `CHK("tap_link", ev[3:0], capture_tap_link)
        end
        $display("test card_selection done");

        // A stopped card clock holds the old tap and keeps the crossing busy until it runs again.
        @(posedge clk);
        frame     <= 1'b0;
        card_type <= 2'h1;
        repeat (20) @(posedge clk);
        `CHK("tap_held", 4'h7, capture_tap_link)
        reg_rd(sdd_pkg::SDD_OFS_STATUS, rd);
        `CHK("busy_held", 8'h05, rd)
        @(posedge clk);
        frame <= 1'b1;
        n = 0;
        while (capture_tap_link !== 4'hc && n < 60) begin @(posedge clk); n++; end
        `CHK("tap_resumed", 4'hc, capture_tap_link)
        $display("test link_stall done");

        card_type <= 2'h0;
        for (int c = 0; c < 4; c++) chain_check(c[1:0]);
        $display("test chain_depths done");
        test_done();
    end
endmodule

`default_nettype wire
